// >>> logic/pdeip_port.sv
// Purpose: one 8-pin port: drive modes, bidir, slew, edge interrupts
// Assumes: pins synchronous to clk_i; analog pads resolve levels
// Notes: per-pin pad controls leave as registered outputs
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`include "pdeip_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module pdeip_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [7:0] pin_in_i,
  input wire logic [15:0] oe_bus_i,
  input wire logic [7:0] sys_out_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pin_pull_up_o,
  output logic [7:0] pin_pull_down_o,
  output logic [7:0] pin_ibuf_en_o,
  output logic [7:0] pin_slow_slew_o,
  output logic [7:0] pin_hyst_o,
  output logic [7:0] pin_reg_high_o,
  output logic [7:0] pin_sys_in_o,
  output logic port_lvttl_o,
  output pdeip_pkg::pdeip_ref_t pair_ref_o [4],
  output logic port_irq_o
);
  import pdeip_pkg::*;

  // ********************************************************
  // configuration state
  // ********************************************************
  logic [7:0] port_output_data; // software data per pin
  logic [7:0] drive_code_bits [3]; // port-form planes of the drive code
  logic [7:0] pin_slew_select; // 1 = slow edges
  logic [7:0] bidir_en; // hardware controls the driver
  logic [7:0] in_disable; // input buffer forced off
  logic [7:0] bypass_en; // pin follows system output
  logic lvttl_sel; // port threshold select
  logic [7:0] reg_high; // special pin regulated high level
  logic [7:0] hyst_en; // special pin hysteresis
  pdeip_ref_t ref_sel [4]; // one reference per pin pair
  logic [3:0] oe_sel [8]; // which enable line steers each pin
  logic [15:0] int_type; // two edge bits per pin
  logic [7:0] int_status; // sticky edge flags
  logic [7:0] pin_prev; // last sampled input level

  // ********************************************************
  // bus decode
  // ********************************************************
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [7:0] off;
  logic [7:0] wbyte;
  logic [2:0] pin_idx;
  logic pin_form;

  // a held request is taken every other cycle: the pending ack masks it
  // only in the answer cycle, so the master must drop stb before the next transfer
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
  assign rd_en = bus_req && !wb_we_i;
  assign off = wb_adr_i[7:0];
  assign wbyte = wb_dat_i[7:0];
  assign pin_idx = off[4:2];
  // pin form words sit at 0x40..0x5C, one per pin
  assign pin_form = (off >= `PDEIP_OFF_PIN0) && (off <= `PDEIP_OFF_PIN7) && (off[1:0] == 2'b00);

  // drive code of pin n rebuilt from its planes
  function automatic pdeip_drive_t drive_of(input int n);
    drive_of = pdeip_drive_t'({drive_code_bits[2][n], drive_code_bits[1][n],
                               drive_code_bits[0][n]});
  endfunction

  // write one pin's bit of a bit plane, for the pin form
  function automatic logic [7:0] merge_bit(input logic [7:0] cur, input logic b);
    logic [7:0] r;
    r = cur;
    r[pin_idx] = b;
    merge_bit = r;
  endfunction

  // ********************************************************
  // data and plane registers, both forms share state
  // ********************************************************
  // port form writes all pins, pin form writes one pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_output_data <= `PDEIP_RST_BYTE;
      drive_code_bits[0] <= `PDEIP_RST_BYTE;
      drive_code_bits[1] <= `PDEIP_RST_BYTE;
      drive_code_bits[2] <= `PDEIP_RST_BYTE;
      pin_slew_select <= `PDEIP_RST_BYTE;
      bidir_en <= `PDEIP_RST_BYTE;
      in_disable <= `PDEIP_RST_BYTE;
    end else if (wr_en && pin_form) begin
      port_output_data <= merge_bit(port_output_data, wbyte[`PDEIP_PIN_DATA]);
      drive_code_bits[0] <= merge_bit(drive_code_bits[0], wbyte[`PDEIP_PIN_DRV_LO]);
      drive_code_bits[1] <= merge_bit(drive_code_bits[1], wbyte[`PDEIP_PIN_DRV_LO + 1]);
      drive_code_bits[2] <= merge_bit(drive_code_bits[2], wbyte[`PDEIP_PIN_DRV_HI]);
      pin_slew_select <= merge_bit(pin_slew_select, wbyte[`PDEIP_PIN_SLEW]);
      bidir_en <= merge_bit(bidir_en, wbyte[`PDEIP_PIN_BIDIR]);
      in_disable <= merge_bit(in_disable, wbyte[`PDEIP_PIN_INDIS]);
    end else if (wr_en) begin
      unique case (off)
        `PDEIP_OFF_DATA: port_output_data <= wbyte;
        `PDEIP_OFF_DRV0: drive_code_bits[0] <= wbyte;
        `PDEIP_OFF_DRV1: drive_code_bits[1] <= wbyte;
        `PDEIP_OFF_DRV2: drive_code_bits[2] <= wbyte;
        `PDEIP_OFF_SLEW: pin_slew_select <= wbyte;
        `PDEIP_OFF_BIDIR: bidir_en <= wbyte;
        `PDEIP_OFF_INDIS: in_disable <= wbyte;
        default: begin
          // other offsets belong to other processes
        end
      endcase
    end
  end

  // ********************************************************
  // port control and special pin registers
  // ********************************************************
  // ctl: bit0 lvttl; also bypass at bits 15:8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvttl_sel <= `PDEIP_RST_CTL;
      bypass_en <= `PDEIP_RST_BYTE;
      reg_high <= `PDEIP_RST_BYTE;
      hyst_en <= `PDEIP_RST_BYTE;
      int_type <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        ref_sel[i] <= PDEIP_REF_HALF_SUPPLY;
      end
      for (int i = 0; i < 8; i++) begin
        oe_sel[i] <= 4'h0;
      end
    end else if (bus_req && wb_we_i) begin
      unique case (off)
        `PDEIP_OFF_CTL: begin
          if (wb_sel_i[0]) lvttl_sel <= wb_dat_i[0];
          if (wb_sel_i[1]) bypass_en <= wb_dat_i[15:8];
        end
        `PDEIP_OFF_INTTYPE: begin
          if (wb_sel_i[0]) int_type[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) int_type[15:8] <= wb_dat_i[15:8];
        end
        `PDEIP_OFF_SPREG: if (wb_sel_i[0]) reg_high <= wbyte;
        `PDEIP_OFF_SPHYST: if (wb_sel_i[0]) hyst_en <= wbyte;
        `PDEIP_OFF_REFSEL: begin
          if (wb_sel_i[0]) begin
            for (int i = 0; i < 4; i++) begin
              ref_sel[i] <= pdeip_ref_t'(wbyte[2*i +: 2]);
            end
          end
        end
        `PDEIP_OFF_OESEL: begin
          // four bits per pin pick one of sixteen lines
          for (int i = 0; i < 8; i++) begin
            if (wb_sel_i[i/2]) oe_sel[i] <= wb_dat_i[4*i +: 4];
          end
        end
        default: begin
          // handled elsewhere or unmapped
        end
      endcase
    end
  end

  // ********************************************************
  // edge detection and sticky status
  // ********************************************************
  // runs on the free clock only, no sleep gating, so it can wake the part
  logic [7:0] in_level;
  logic [7:0] edge_hit;
  logic [7:0] clr_mask;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // analog mode and disabled buffers give a constant low
      // limitation: leaving analog mode with the pin high reads as a
      // rising edge, so set the edge type after the drive code
      in_level[i] = pin_in_i[i] && (drive_of(i) != PDEIP_ANALOG_HIZ) && !in_disable[i];
      unique case (pdeip_edge_t'(int_type[2*i +: 2]))
        PDEIP_EDGE_NONE: edge_hit[i] = 1'b0;
        PDEIP_EDGE_RISE: edge_hit[i] = in_level[i] && !pin_prev[i];
        PDEIP_EDGE_FALL: edge_hit[i] = !in_level[i] && pin_prev[i];
        PDEIP_EDGE_BOTH: edge_hit[i] = in_level[i] ^ pin_prev[i];
      endcase
    end
  end

  // read clears all bits, write-one clears chosen ones
  always_comb begin
    clr_mask = 8'h00;
    if (bus_req && off == `PDEIP_OFF_IRQSTAT) begin
      if (!wb_we_i) begin
        clr_mask = 8'hFF;
      end else if (wb_sel_i[0]) begin
        clr_mask = wbyte;
      end
    end
  end

  // a new edge wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev <= `PDEIP_RST_BYTE;
      int_status <= `PDEIP_RST_BYTE;
    end else begin
      pin_prev <= in_level;
      int_status <= (int_status & ~clr_mask) | edge_hit;
    end
  end

  // one request line for the whole port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_irq_o <= 1'b0;
    end else begin
      port_irq_o <= |((int_status & ~clr_mask) | edge_hit);
    end
  end

  // ********************************************************
  // pad drive decode
  // ********************************************************
  logic [7:0] next_out;
  logic [7:0] next_oe;
  logic [7:0] next_up;
  logic [7:0] next_down;
  logic [7:0] next_ibuf;
  logic [7:0] next_slow;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic d;
      pdeip_drive_t m;
      d = bypass_en[i] ? sys_out_i[i] : port_output_data[i];
      m = drive_of(i);
      // line low turns the pin into a digital input
      if (bidir_en[i] && !oe_bus_i[oe_sel[i]]) begin
        m = PDEIP_DIGITAL_HIZ;
      end
      // resistive modes on regulated special pins fall back to strong drive
      if (reg_high[i] && (m == PDEIP_RES_UP || m == PDEIP_RES_DOWN || m == PDEIP_RES_BOTH)) begin
        m = PDEIP_STRONG;
      end
      next_out[i] = d;
      next_oe[i] = 1'b0;
      next_up[i] = 1'b0;
      next_down[i] = 1'b0;
      next_ibuf[i] = !in_disable[i];
      unique case (m)
        PDEIP_ANALOG_HIZ: next_ibuf[i] = 1'b0;
        PDEIP_DIGITAL_HIZ: next_oe[i] = 1'b0;
        PDEIP_RES_UP: begin
          next_oe[i] = !d;
          next_up[i] = d;
        end
        PDEIP_RES_DOWN: begin
          next_oe[i] = d;
          next_down[i] = !d;
        end
        PDEIP_OD_LOW: next_oe[i] = !d;
        PDEIP_OD_HIGH: next_oe[i] = d;
        PDEIP_STRONG: next_oe[i] = 1'b1;
        PDEIP_RES_BOTH: begin
          next_up[i] = d;
          next_down[i] = !d;
        end
      endcase
      // slew only matters on strong and open-drain
      next_slow[i] = pin_slew_select[i] &&
                     (m == PDEIP_STRONG || m == PDEIP_OD_LOW || m == PDEIP_OD_HIGH);
    end
  end

  // registered pad controls
  // one cycle of latency traded for glitch-free pad enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o <= 8'h00;
      pin_oe_o <= 8'h00;
      pin_pull_up_o <= 8'h00;
      pin_pull_down_o <= 8'h00;
      pin_ibuf_en_o <= 8'h00;
      pin_slow_slew_o <= 8'h00;
      pin_hyst_o <= 8'h00;
      pin_reg_high_o <= 8'h00;
      pin_sys_in_o <= 8'h00;
      port_lvttl_o <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        pair_ref_o[i] <= PDEIP_REF_HALF_SUPPLY;
      end
    end else begin
      pin_out_o <= next_out;
      pin_oe_o <= next_oe;
      pin_pull_up_o <= next_up;
      pin_pull_down_o <= next_down;
      pin_ibuf_en_o <= next_ibuf;
      pin_slow_slew_o <= next_slow;
      pin_hyst_o <= hyst_en;
      pin_reg_high_o <= reg_high;
      pin_sys_in_o <= in_level;
      port_lvttl_o <= lvttl_sel;
      for (int i = 0; i < 4; i++) begin
        pair_ref_o[i] <= ref_sel[i];
      end
    end
  end

  // ********************************************************
  // bus answer
  // ********************************************************
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (pin_form) begin
      rdata[7:0] = {in_disable[pin_idx], bidir_en[pin_idx], pin_slew_select[pin_idx],
                    drive_code_bits[2][pin_idx], drive_code_bits[1][pin_idx],
                    drive_code_bits[0][pin_idx], in_level[pin_idx],
                    port_output_data[pin_idx]};
    end else begin
      unique case (off)
        `PDEIP_OFF_DATA: rdata[7:0] = port_output_data;
        `PDEIP_OFF_STATE: rdata[7:0] = in_level;
        `PDEIP_OFF_DRV0: rdata[7:0] = drive_code_bits[0];
        `PDEIP_OFF_DRV1: rdata[7:0] = drive_code_bits[1];
        `PDEIP_OFF_DRV2: rdata[7:0] = drive_code_bits[2];
        `PDEIP_OFF_SLEW: rdata[7:0] = pin_slew_select;
        `PDEIP_OFF_BIDIR: rdata[7:0] = bidir_en;
        `PDEIP_OFF_INDIS: rdata[7:0] = in_disable;
        `PDEIP_OFF_CTL: rdata[15:0] = {bypass_en, 7'h00, lvttl_sel};
        `PDEIP_OFF_IRQSTAT: rdata[7:0] = int_status;
        `PDEIP_OFF_INTTYPE: rdata[15:0] = int_type;
        `PDEIP_OFF_SPREG: rdata[7:0] = reg_high;
        `PDEIP_OFF_SPHYST: rdata[7:0] = hyst_en;
        `PDEIP_OFF_REFSEL: rdata[7:0] = {ref_sel[3], ref_sel[2], ref_sel[1], ref_sel[0]};
        `PDEIP_OFF_OESEL: rdata = {oe_sel[7], oe_sel[6], oe_sel[5], oe_sel[4],
                                   oe_sel[3], oe_sel[2], oe_sel[1], oe_sel[0]};
        default: rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // single-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (rd_en) begin
        wb_dat_o <= rdata;
      end
    end
  end

endmodule

`default_nettype wire

// >>> logic/pdeip_defs.svh
// Purpose: constants of the pin drive and edge interrupt port
// Assumes: one 8-pin port, classic Wishbone, byte offsets
// Notes: offsets are byte addresses of 32-bit aligned words
//
// Overview of operation
// - three-bit drive code selects eight modes
// - analog high-z: no driver, no input; reset
// - digital high-z: driver off, input readable
// - resistive up/down: one resistive, other strong
// - no resistive modes on regulated special pin
// - open drain: one state floats, input readable
// - combined resistive: always through resistor
// - port form: bit n steers pin n
// - pin form gathers eight bits, shared state
// - output enable switches to digital high-z
// - sixteen enable lines routable to pins
// - slew select only in strong/open-drain
// - eight pins feed one port interrupt
// - per-pin rising, falling, both or none
// - qualifying edge sets status, raises request
// - edge detection runs in every sleep
// - edges only, no level interrupts
// - port-wide cmos or lvttl threshold
// - per-pin input buffer disable
// - special pin selects regulated high output
// - pin pairs share one input reference
// - special pin hysteresis enable
`ifndef PDEIP_DEFS_SVH
`define PDEIP_DEFS_SVH

// ********************************************************
// register byte offsets
// ********************************************************
`define PDEIP_OFF_DATA 8'h00
`define PDEIP_OFF_STATE 8'h04
`define PDEIP_OFF_DRV0 8'h08
`define PDEIP_OFF_DRV1 8'h0C
`define PDEIP_OFF_DRV2 8'h10
`define PDEIP_OFF_SLEW 8'h14
`define PDEIP_OFF_BIDIR 8'h18
`define PDEIP_OFF_INDIS 8'h1C
`define PDEIP_OFF_CTL 8'h20
`define PDEIP_OFF_IRQSTAT 8'h24
`define PDEIP_OFF_INTTYPE 8'h28
`define PDEIP_OFF_SPREG 8'h2C
`define PDEIP_OFF_SPHYST 8'h30
`define PDEIP_OFF_REFSEL 8'h34
`define PDEIP_OFF_OESEL 8'h38
`define PDEIP_OFF_PIN0 8'h40
`define PDEIP_OFF_PIN7 8'h5C

// ********************************************************
// pin form field positions
// ********************************************************
`define PDEIP_PIN_DATA 0
`define PDEIP_PIN_STATE 1
`define PDEIP_PIN_DRV_LO 2
`define PDEIP_PIN_DRV_HI 4
`define PDEIP_PIN_SLEW 5
`define PDEIP_PIN_BIDIR 6
`define PDEIP_PIN_INDIS 7

// ********************************************************
// reset values
// ********************************************************
`define PDEIP_RST_DM 3'h0
`define PDEIP_RST_BYTE 8'h00
`define PDEIP_RST_CTL 1'b0

`endif

// >>> logic/pdeip_pkg.sv
// Purpose: types of the pin drive and edge interrupt port
// Assumes: one 8-pin port
// Notes: drive code values are fixed by the enum order
package pdeip_pkg;
  // drive code of one pin
  typedef enum logic [2:0] {
    PDEIP_ANALOG_HIZ,
    PDEIP_DIGITAL_HIZ,
    PDEIP_RES_UP,
    PDEIP_RES_DOWN,
    PDEIP_OD_LOW,
    PDEIP_OD_HIGH,
    PDEIP_STRONG,
    PDEIP_RES_BOTH
  } pdeip_drive_t;
  // edge selection of one pin
  typedef enum logic [1:0] {
    PDEIP_EDGE_NONE,
    PDEIP_EDGE_RISE,
    PDEIP_EDGE_FALL,
    PDEIP_EDGE_BOTH
  } pdeip_edge_t;
  // input reference of one special pin pair
  typedef enum logic [1:0] {
    PDEIP_REF_HALF_SUPPLY,
    PDEIP_REF_POINT4_SUPPLY,
    PDEIP_REF_HALF_REF,
    PDEIP_REF_FULL_REF
  } pdeip_ref_t;
endpackage

// >>> test/pdeip_port_sva.sv
// Purpose: port-level checker for the pdeip port
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every pdeip_port instance below
`timescale 1ns/10ps
`default_nettype none
module pdeip_port_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pin_pull_up_o,
  input wire logic [7:0] pin_pull_down_o,
  input wire logic [7:0] pin_ibuf_en_o,
  input wire logic [7:0] pin_sys_in_o,
  input wire logic port_irq_o
);
  // ****************************************
  // bus handshake and pad relations
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request the slave has not answered yet
  sequence s_req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // answer lasts exactly one cycle
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next_edge: assert property (s_req_taken |=> s_ack_pulse)
    else $error("ack is not a one-cycle answer");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  a_reset_state: assert property ($fell(rst_i) |-> !port_irq_o &&
    (pin_oe_o | pin_pull_up_o | pin_pull_down_o | pin_ibuf_en_o) == 8'h00)
    else $error("pads not parked after reset");
  a_pull_exclusive: assert property ((pin_pull_up_o & pin_pull_down_o) == 8'h00)
    else $error("both pulls on one pin");
  a_pull_or_strong: assert property ((pin_oe_o & (pin_pull_up_o | pin_pull_down_o)) == 8'h00)
    else $error("pull resistor beside strong drive");
  // one cycle of slack: buffer enable and input level may settle apart
  a_gated_input: assert property ((pin_sys_in_o & ~pin_ibuf_en_o & ~$past(pin_ibuf_en_o)) == 8'h00)
    else $error("input level through a disabled buffer");
  a_edge_only: assert property ($rose(port_irq_o) |-> $changed(pin_sys_in_o))
    else $error("request raised without an input edge");
  a_irq_bus_clear: assert property ($fell(port_irq_o) |->
    $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("request dropped without a bus access");
endmodule
bind pdeip_port pdeip_port_chk u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .pin_oe_o(pin_oe_o),
  .pin_pull_up_o(pin_pull_up_o),
  .pin_pull_down_o(pin_pull_down_o),
  .pin_ibuf_en_o(pin_ibuf_en_o),
  .pin_sys_in_o(pin_sys_in_o),
  .port_irq_o(port_irq_o)
);
`default_nettype wire

// >>> test/pdeip_pad_model.sv
// Purpose: board circuitry on the eight port pins
// Assumes: levels settle within one clock
// Notes: an undriven pin wanders every cycle
`timescale 1ns/10ps
`default_nettype none
module pdeip_pad_model (
  input wire logic clk_i,
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] pin_pull_up_i,
  input wire logic [7:0] pin_pull_down_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_level_o
);
  // known start so a floating pin toggles instead of staying unknown
  initial pin_level_o = 8'h00;
  // resolve each wire: strong, then board source, then pulls
  always @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i] === 1'b1) begin // board yields to a strongly driven pin
        pin_level_o[i] <= pin_out_i[i];
      end else if (ext_en_i[i]) begin // board source beats the weak pulls
        pin_level_o[i] <= ext_val_i[i];
      end else if (pin_pull_up_i[i] || pin_pull_down_i[i]) begin
        pin_level_o[i] <= pin_pull_up_i[i];
      end else begin // floating: no trustworthy level
        pin_level_o[i] <= ~pin_level_o[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Purpose: self-checking bench for the pdeip port
// Assumes: 125 MHz clock, one-cycle bus answer
// Notes: drive modes run from a table, the rest by hand
`include "pdeip_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pdeip_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] wb_adr = 32'h0, wb_dat = 32'h0, rd_dat, dat_o;
  logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, ack_o, lvttl, irq;
  logic [3:0] wb_sel = 4'h0;
  logic [15:0] oe_bus = 16'h0000;
  logic [7:0] sys_out = 8'h00;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00, pin_in, p_out, p_oe, p_pu, p_pd;
  logic [7:0] p_ib, p_slw, p_hy, p_rh, p_si;
  pdeip_ref_t pair_ref [4];
  int n_fail = 0, check_count = 0, cycles = 0;
  // row: drive code, data, then expected oe, pull up, pull down, input buffer
  logic [7:0] rows [16] = '{8'h00, 8'h10, 8'h21, 8'h31, 8'h49, 8'h55, 8'h63, 8'h79,
    8'h89, 8'h91, 8'hA1, 8'hB9, 8'hC9, 8'hD9, 8'hE3, 8'hF5};
  initial forever #4 clk_i = ~clk_i;
  pdeip_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_dat_o(dat_o), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o(ack_o), .pin_in_i(pin_in), .oe_bus_i(oe_bus),
    .sys_out_i(sys_out), .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_pull_up_o(p_pu),
    .pin_pull_down_o(p_pd), .pin_ibuf_en_o(p_ib), .pin_slow_slew_o(p_slw),
    .pin_hyst_o(p_hy), .pin_reg_high_o(p_rh), .pin_sys_in_o(p_si),
    .port_lvttl_o(lvttl), .pair_ref_o(pair_ref), .port_irq_o(irq));
  pdeip_pad_model PADS (.clk_i(clk_i), .pin_out_i(p_out), .pin_oe_i(p_oe),
    .pin_pull_up_i(p_pu), .pin_pull_down_i(p_pd), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_level_o(pin_in));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {24'h0, a};
    wb_dat <= d;
    wb_sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    rd_dat = dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk(n, 32'h2);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd_dat, e);
  endtask
  // let registered pad outputs land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    chk(p_oe | p_pu | p_pd | p_ib, 8'h00);
    chk(irq, 1'b0);
    rd_chk(`PDEIP_OFF_DRV2, 32'h0);
    rd_chk(8'h3C, 32'h0);
    $display("test reset done");
    wb(1'b1, `PDEIP_OFF_SLEW, 32'hFF);
    foreach (rows[i]) begin // every drive code, both data states
      wb(1'b1, `PDEIP_OFF_DRV0, {8{rows[i][5]}});
      wb(1'b1, `PDEIP_OFF_DRV1, {8{rows[i][6]}});
      wb(1'b1, `PDEIP_OFF_DRV2, {8{rows[i][7]}});
      wb(1'b1, `PDEIP_OFF_DATA, {8{rows[i][4]}});
      settle(2);
      chk(p_oe, {8{rows[i][3]}});
      chk(p_pu, {8{rows[i][2]}});
      chk(p_pd, {8{rows[i][1]}});
      chk(p_ib, {8{rows[i][0]}});
      if (rows[i][3]) chk(p_out, {8{rows[i][4]}});
      if (rows[i][7:5] == 3'h0) chk(p_si, 8'h00);
      if (rows[i][7:5] >= 3'h2) chk(p_slw, {8{rows[i][7:5] inside {3'h4, 3'h5, 3'h6}}});
    end
    $display("test drive table done");
    for (logic [7:0] a = 8'h08; a <= 8'h14; a += 8'h04) wb(1'b1, a, 32'h0);
    wb(1'b1, `PDEIP_OFF_DATA, 32'h0);
    // slow edges on a pin that only changes at register speed
    wb(1'b1, `PDEIP_OFF_PIN0 + 8'h0C, 32'h39);
    rd_chk(`PDEIP_OFF_DRV0, 32'h00);
    rd_chk(`PDEIP_OFF_DRV1, 32'h08);
    rd_chk(`PDEIP_OFF_DRV2, 32'h08);
    rd_chk(`PDEIP_OFF_SLEW, 32'h08);
    rd_chk(`PDEIP_OFF_DATA, 32'h08);
    settle(2);
    chk(p_oe, 8'h08);
    chk(p_slw, 8'h08);
    $display("test pin form done");
    @(posedge clk_i);
    oe_bus <= 16'h7FFF;
    wb(1'b1, `PDEIP_OFF_BIDIR, 32'h08);
    wb(1'b1, `PDEIP_OFF_OESEL, 32'h0000F000);
    settle(2);
    chk(p_oe, 8'h00);
    chk(p_ib[3], 1'b1);
    @(posedge clk_i);
    oe_bus <= 16'h8000;
    settle(2);
    chk(p_oe, 8'h08);
    $display("test bidir done");
    wb(1'b1, `PDEIP_OFF_PIN0 + 8'h0C, 32'h49);
    settle(2);
    chk(p_pu, 8'h08);
    wb(1'b1, `PDEIP_OFF_SPREG, 32'h08);
    wb(1'b1, `PDEIP_OFF_CTL, 32'h01);
    wb(1'b1, `PDEIP_OFF_SPHYST, 32'hA5);
    wb(1'b1, `PDEIP_OFF_REFSEL, 32'hE4);
    settle(2);
    chk(p_oe, 8'h08);
    chk(p_pu, 8'h00);
    chk(p_rh, 8'h08);
    chk(lvttl, 1'b1);
    chk(p_hy, 8'hA5);
    for (int i = 0; i < 4; i++) chk(pair_ref[i], i[31:0]);
    $display("test special pin done");
    wb(1'b1, `PDEIP_OFF_SPREG, 32'h0);
    wb(1'b1, `PDEIP_OFF_BIDIR, 32'h0);
    wb(1'b1, `PDEIP_OFF_DRV1, 32'h0);
    wb(1'b1, `PDEIP_OFF_DRV0, 32'hFF);
    @(posedge clk_i);
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    settle(4);
    chk(p_si, 8'hFF);
    rd_chk(`PDEIP_OFF_STATE, 32'hFF);
    wb(1'b1, `PDEIP_OFF_INDIS, 32'h0F);
    settle(2);
    chk(p_si, 8'hF0);
    chk(p_ib, 8'hF0);
    wb(1'b1, `PDEIP_OFF_INDIS, 32'h0);
    @(posedge clk_i);
    ext_val <= 8'h00;
    settle(4);
    wb(1'b1, `PDEIP_OFF_INTTYPE, 32'hE4);
    rd_chk(`PDEIP_OFF_IRQSTAT, 32'h0);
    @(posedge clk_i);
    ext_val <= 8'hFF;
    settle(8);
    chk(irq, 1'b1);
    rd_chk(`PDEIP_OFF_IRQSTAT, 32'h0A);
    settle(1);
    chk(irq, 1'b0);
    @(posedge clk_i);
    ext_val <= 8'h00;
    settle(6);
    wb(1'b1, `PDEIP_OFF_IRQSTAT, 32'h04);
    settle(1);
    chk(irq, 1'b1);
    rd_chk(`PDEIP_OFF_IRQSTAT, 32'h08);
    settle(1);
    chk(irq, 1'b0);
    $display("test interrupts done");
    // system output steers the pins once bypass is on
    @(posedge clk_i);
    sys_out <= 8'hA5;
    wb(1'b1, `PDEIP_OFF_DRV0, 32'h0);
    wb(1'b1, `PDEIP_OFF_DRV1, 32'hFF);
    wb(1'b1, `PDEIP_OFF_DRV2, 32'hFF);
    wb(1'b1, `PDEIP_OFF_CTL, 32'h0000FF00);
    settle(2);
    chk(p_oe, 8'hFF);
    chk(p_out, 8'hA5);
    rd_chk(`PDEIP_OFF_CTL, 32'h0000FF00);
    $display("test bypass done");
    // reset in mid-run must park every pad again
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    chk(p_oe | p_pu | p_pd | p_ib | p_out, 8'h00);
    chk(irq, 1'b0);
    rd_chk(`PDEIP_OFF_CTL, 32'h0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
